// ===== verification/hv_measure_path_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
   error_cnt++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module hv_measure_path_control_tb_top;
   import hv_meas_pkg::*;
   logic        aclk, aresetn;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, pull_en;
   logic [1:0]  bresp, rresp, rs;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   mode_t       op_mode;
   logic        sleep_cmd, other_wake_src, hv_src, gp_src, hv_pin, gp_pin;
   logic        measure_switch, inputs_gated, fail_output, adc_in;
   logic        hv_wake_armed, gp_wake_armed, restart_req, irq;
   logic [31:0] rd;
   int          error_cnt, checks, n;
   mode_t       mlist [6];

   hv_measure_path_control i_hv_measure_path_control (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .op_mode(op_mode), .sleep_cmd(sleep_cmd),
      .other_wake_src(other_wake_src), .hv_wake_input(hv_pin),
      .fail_gp_pin(gp_pin), .measure_switch(measure_switch),
      .pull_en(pull_en), .inputs_gated(inputs_gated),
      .fail_output(fail_output), .hv_wake_armed(hv_wake_armed),
      .gp_wake_armed(gp_wake_armed), .restart_req(restart_req), .irq(irq));

   pin_env_model i_pin_env_model (
      .hv_src(hv_src), .gp_src(gp_src), .measure_switch(measure_switch),
      .hv_wake_input(hv_pin), .fail_gp_pin(gp_pin), .adc_in(adc_in));

   ////////////////////////////////////////////////////////////////////////
   // clock, and a watchdog well beyond the few hundred cycles needed
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      test_done();
   end

   task automatic test_done();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // bus tasks; bready/rready stay high so no release shares a step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_d, w_d;
      int   k;
      aw_d = 1'b0;
      w_d = 1'b0;
      k = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_d && w_d) && k < 100) begin
         @(posedge aclk);
         k++;
         if (!aw_d && awready === 1'b1) begin
            aw_d = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_d && wready === 1'b1) begin
            w_d = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge aclk);
         k++;
      end while (bvalid !== 1'b1 && k < 100);
      rs = bresp;
      if (k >= 100) error_cnt++;
   endtask

   task automatic rdr(input logic [7:0] a);
      int k;
      k = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
      end while (arready !== 1'b1 && k < 100);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         k++;
      end while (rvalid !== 1'b1 && k < 100);
      rd = rdata;
      rs = rresp;
      if (k >= 100) error_cnt++;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rdr(a);
      `CHK("register", e, rd)
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, arvalid, sleep_cmd, other_wake_src} = '0;
      {hv_src, gp_src} = '0;
      wstrb = 4'hf;
      bready = 1'b1;
      rready = 1'b1;
      op_mode = MODE_INIT;
      mlist = '{MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_INIT,
                MODE_FAIL_SAFE, MODE_NORMAL};
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // defaults after reset
      `CHK("switch", 1'b0, measure_switch)
      `CHK("gated", 1'b0, inputs_gated)
      rchk(OFS_CTRL, 32'h0);
      rchk(OFS_GPIO, {29'h0, GPIO_RST});
      rchk(OFS_WAKE_CFG, {27'h0, WCFG_RST});
      rchk(OFS_IRQ_STAT, {29'h0, IRQ_RST});
      op_mode <= MODE_NORMAL;
      // disabled path: pulls follow the config, wake and level follow the pins
      wr(OFS_WAKE_CFG, 32'h15);
      repeat (2) @(posedge aclk);
      `CHK("pulls", 4'h5, pull_en)
      `CHK("hv armed", 1'b1, hv_wake_armed)
      hv_src <= 1'b1;
      repeat (3) @(posedge aclk);
      rchk(OFS_STAT_LO, 32'h1);
      rchk(OFS_LVL, 32'h1);
      rchk(OFS_IRQ_STAT, 32'h2);
      `CHK("irq masked", 1'b0, irq)
      wr(OFS_IRQ_EN, 32'h7);
      repeat (2) @(posedge aclk);
      `CHK("irq", 1'b1, irq)
      wr(OFS_IRQ_CLR, 32'h2);
      wr(OFS_STAT_LO, 32'h1);
      repeat (2) @(posedge aclk);
      `CHK("irq cleared", 1'b0, irq)
      rchk(OFS_IRQ_CLR, 32'h0);
      hv_src <= 1'b0;
      // shared pin as wake input while the path is disabled
      wr(OFS_GPIO, {29'h0, GPIO_WAKE});
      gp_src <= 1'b1;
      repeat (3) @(posedge aclk);
      `CHK("gp armed", 1'b1, gp_wake_armed)
      rchk(OFS_STAT_HI, 32'h1);
      rchk(OFS_LVL, 32'h2);
      rchk(OFS_IRQ_STAT, 32'h4);
      gp_src <= 1'b0;
      wr(OFS_STAT_HI, 32'h1);
      wr(OFS_IRQ_CLR, 32'h4);
      // pin set to fail output: test bit drives it, enabling is refused
      wr(OFS_GPIO, {29'h0, GPIO_FO});
      wr(OFS_CTRL, 32'h2);
      repeat (2) @(posedge aclk);
      `CHK("fail out", 1'b1, fail_output)
      wr(OFS_CTRL, 32'h3);
      repeat (2) @(posedge aclk);
      `CHK("switch", 1'b0, measure_switch)
      rdr(OFS_CTRL);
      `CHK("enable", 1'b0, rd[CTRL_MEAS_BIT])
      rchk(OFS_IRQ_STAT, 32'h1);
      // software sets the pin off before enabling
      wr(OFS_CTRL, 32'h0);
      wr(OFS_GPIO, {29'h0, GPIO_OFF});
      wr(OFS_IRQ_CLR, 32'h7);
      // enabled in normal mode
      wr(OFS_CTRL, 32'h1);
      repeat (2) @(posedge aclk);
      `CHK("switch", 1'b1, measure_switch)
      `CHK("pulls", 4'h0, pull_en)
      `CHK("gated", 1'b1, inputs_gated)
      `CHK("hv armed", 1'b0, hv_wake_armed)
      `CHK("gp armed", 1'b0, gp_wake_armed)
      `CHK("fail out", 1'b0, fail_output)
      wr(OFS_WAKE_CFG, 32'h1a);
      `CHK("bresp", RESP_OKAY, rs)
      rchk(OFS_WAKE_CFG, 32'h1a);
      `CHK("pulls", 4'h0, pull_en)
      hv_src <= 1'b1;
      repeat (3) @(posedge aclk);
      `CHK("adc", 1'b1, adc_in)
      rchk(OFS_STAT_LO, 32'h0);
      rchk(OFS_STAT_HI, 32'h0);
      rchk(OFS_LVL, 32'h0);
      wr(OFS_GPIO, {29'h0, GPIO_WAKE});
      rchk(OFS_IRQ_STAT, 32'h1);
      wr(OFS_GPIO, {29'h0, GPIO_OFF});
      wr(OFS_IRQ_CLR, 32'h7);
      hv_src <= 1'b0;
      // every mode: closed only in normal, enable kept
      foreach (mlist[i]) begin
         op_mode <= mlist[i];
         repeat (2) @(posedge aclk);
         `CHK("switch", mlist[i] == MODE_NORMAL, measure_switch)
         rdr(OFS_CTRL);
         `CHK("enable kept", 1'b1, rd[CTRL_MEAS_BIT])
      end
      // sleep with only pin wake sources, then with another source
      for (int s = 0; s < 2; s++) begin
         other_wake_src <= s[0];
         @(posedge aclk);
         n = 0;
         sleep_cmd <= 1'b1;
         repeat (4) begin
            @(posedge aclk);
            sleep_cmd <= 1'b0;
            if (restart_req === 1'b1) n++;
         end
         `CHK("restarts", (s == 0) ? 1 : 0, n)
         rchk(OFS_IRQ_STAT, (s == 0) ? 32'h1 : 32'h0);
         wr(OFS_IRQ_CLR, 32'h1);
      end
      // disabled fail-safe entry arms the hv input
      wr(OFS_WAKE_CFG, 32'h0);
      wr(OFS_CTRL, 32'h0);
      op_mode <= MODE_FAIL_SAFE;
      repeat (3) @(posedge aclk);
      `CHK("hv armed", 1'b1, hv_wake_armed)
      `CHK("switch", 1'b0, measure_switch)
      // unmapped place answers with an error
      rdr(8'h40);
      `CHK("rresp", RESP_SLVERR, rs)
      wr(8'h40, 32'h1);
      `CHK("bresp", RESP_SLVERR, rs)
      test_done();
   end
endmodule // hv_measure_path_control_tb_top

// ===== verification/pin_env_model.sv
`timescale 1ns/1ps
// pins and adc input as seen from the board side
module pin_env_model (
   input  wire logic hv_src,          // level applied at the hv pin
   input  wire logic gp_src,          // level the shared pin load drives
   input  wire logic measure_switch,  // routing switch closed
   output logic      hv_wake_input,   // hv pin level into the block
   output logic      fail_gp_pin,     // shared pin level into the block
   output logic      adc_in           // level behind the divider
);
   assign hv_wake_input = hv_src;
   // closed switch ties the shared pin to the hv pin, the load loses it
   assign fail_gp_pin   = measure_switch ? hv_src : gp_src;
   // divider only carries a level while the path is closed
   assign adc_in        = measure_switch & hv_src;
endmodule // pin_env_model

// ===== verilog/hv_meas_pkg.sv
package hv_meas_pkg;

   // operating modes handed in by the mode controller
   typedef enum logic [2:0] {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESTART,
      MODE_FAIL_SAFE
   } mode_t;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_GPIO     = 8'h04;
   localparam logic [7:0] OFS_WAKE_CFG = 8'h08;
   localparam logic [7:0] OFS_STAT_LO  = 8'h0c;
   localparam logic [7:0] OFS_STAT_HI  = 8'h10;
   localparam logic [7:0] OFS_LVL      = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h1c;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;
   localparam logic [7:0] OFS_STATUS   = 8'h24;

   // field positions
   localparam int CTRL_MEAS_BIT  = 0;
   localparam int CTRL_FOT_BIT   = 1;
   localparam int WCFG_HVWK_BIT  = 4;
   localparam int IRQ_FAIL_BIT   = 0;
   localparam int IRQ_HVWK_BIT   = 1;
   localparam int IRQ_GPWK_BIT   = 2;

   // fail/general-purpose pin function codes
   localparam logic [2:0] GPIO_OFF  = 3'h0;
   localparam logic [2:0] GPIO_FO   = 3'h1;
   localparam logic [2:0] GPIO_WAKE = 3'h2;

   // reset values
   localparam logic [2:0] GPIO_RST = 3'h0;
   localparam logic [4:0] WCFG_RST = 5'h00;
   localparam logic [2:0] IRQ_RST  = 3'h0;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== verilog/hv_measure_path_control.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module hv_measure_path_control
   import hv_meas_pkg::*;
(
   input  wire logic        aclk,            // 100 MHz clock
   input  wire logic        aresetn,         // sync reset, low
   input  wire logic [7:0]  s_axi_awaddr,    // write address
   input  wire logic        s_axi_awvalid,   // write address valid
   output logic             s_axi_awready,   // write address ready
   input  wire logic [31:0] s_axi_wdata,     // write data
   input  wire logic [3:0]  s_axi_wstrb,     // byte enables
   input  wire logic        s_axi_wvalid,    // write data valid
   output logic             s_axi_wready,    // write data ready
   output logic [1:0]       s_axi_bresp,     // write response
   output logic             s_axi_bvalid,    // write response valid
   input  wire logic        s_axi_bready,    // write response ready
   input  wire logic [7:0]  s_axi_araddr,    // read address
   input  wire logic        s_axi_arvalid,   // read address valid
   output logic             s_axi_arready,   // read address ready
   output logic [31:0]      s_axi_rdata,     // read data
   output logic [1:0]       s_axi_rresp,     // read response
   output logic             s_axi_rvalid,    // read data valid
   input  wire logic        s_axi_rready,    // read data ready
   input  mode_t            op_mode,         // from mode controller
   input  wire logic        sleep_cmd,       // sleep request pulse
   input  wire logic        other_wake_src,  // any other wake source set
   input  wire logic        hv_wake_input,   // hv wake pin level
   input  wire logic        fail_gp_pin,     // shared pin level
   output logic             measure_switch,  // routing switch closed
   output logic [3:0]       pull_en,         // hv up/down, gp up/down
   output logic             inputs_gated,    // pin inputs gated
   output logic             fail_output,     // fail output drive
   output logic             hv_wake_armed,   // hv wake source live
   output logic             gp_wake_armed,   // shared pin wake live
   output logic             restart_req,     // go to restart, pulse
   output logic             irq              // enabled status pending
);

   pin_ctl_if pc ();

   logic        meas_en_r;     // measure_enable
   logic        fo_test_r;     // fail_output_test
   logic [2:0]  gpio_cfg_r;    // gpio_config
   logic [4:0]  wake_cfg_r;    // pulls + hv_wake_enable
   logic        stat_lo_r;     // wake_status_low
   logic        stat_hi_r;     // wake_status_high
   logic [1:0]  lvl_r;         // wake_level_status
   logic [2:0]  irq_stat_r;
   logic [2:0]  irq_en_r;
   logic        aw_got_r;
   logic        w_got_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        wr_go;
   logic        wr_lane0;
   logic        wr_ctrl;
   logic        wr_gpio;
   logic        wr_wcfg;
   logic        wr_stlo;
   logic        wr_sthi;
   logic        wr_clr;
   logic        wr_en;
   logic        wr_map;
   logic        en_refused;
   logic        gpio_fail;
   logic        sleep_fail;
   logic        hv_evt;
   logic        gp_evt;
   logic [2:0]  irq_set;
   logic [31:0] rd_nxt;
   logic        rd_map;

   ////////////////////////////////////////////////////////////////////
   // pin gating decisions
   assign pc.meas_en  = meas_en_r;
   assign pc.mode     = op_mode;
   assign pc.gpio_cfg = gpio_cfg_r;
   assign pc.pull_cfg = wake_cfg_r[3:0];
   assign pc.hv_hv_wake_enable = wake_cfg_r[WCFG_HVWK_BIT];
   assign pc.fo_test  = fo_test_r;
   assign pc.hv_in    = hv_wake_input;
   assign pc.gp_in    = fail_gp_pin;

   pin_gate u_gate (
      .p (pc.gate)
   );

   ////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order
   assign wr_go    = aw_got_r & w_got_r & ~s_axi_bvalid;
   assign wr_lane0 = wr_go & wstrb_r[0];
   assign wr_ctrl  = wr_lane0 & (awaddr_r == OFS_CTRL);
   assign wr_gpio  = wr_lane0 & (awaddr_r == OFS_GPIO);
   assign wr_wcfg  = wr_lane0 & (awaddr_r == OFS_WAKE_CFG);
   assign wr_stlo  = wr_lane0 & (awaddr_r == OFS_STAT_LO);
   assign wr_sthi  = wr_lane0 & (awaddr_r == OFS_STAT_HI);
   assign wr_clr   = wr_lane0 & (awaddr_r == OFS_IRQ_CLR);
   assign wr_en    = wr_lane0 & (awaddr_r == OFS_IRQ_EN);
   assign wr_map   = (awaddr_r <= OFS_STATUS) & (awaddr_r[1:0] == 2'h0);

   // ready drops after each capture so a held valid is not taken twice
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         awaddr_r      <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration registers; pin configs always stored
   assign en_refused = wr_ctrl & wdata_r[CTRL_MEAS_BIT] & ~meas_en_r
                       & (gpio_cfg_r != GPIO_OFF);
   assign gpio_fail  = wr_gpio & meas_en_r & (wdata_r[2:0] != gpio_cfg_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meas_en_r  <= 1'b0;
         fo_test_r  <= 1'b0;
         gpio_cfg_r <= GPIO_RST;
         wake_cfg_r <= WCFG_RST;
      end else begin
         // mode changes never touch the enable bit
         if (wr_ctrl && !en_refused) begin
            meas_en_r <= wdata_r[CTRL_MEAS_BIT];
         end
         if (wr_ctrl) begin
            fo_test_r <= wdata_r[CTRL_FOT_BIT];
         end
         if (wr_gpio) begin
            gpio_cfg_r <= wdata_r[2:0];
         end
         if (wr_wcfg) begin
            wake_cfg_r <= wdata_r[4:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin outputs, one register stage behind mode and enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         measure_switch <= 1'b0;
         pull_en        <= 4'h0;
         inputs_gated   <= 1'b0;
         fail_output    <= 1'b0;
         hv_wake_armed  <= 1'b0;
         gp_wake_armed  <= 1'b0;
      end else begin
         measure_switch <= pc.sw;
         pull_en        <= pc.pulls;
         inputs_gated   <= pc.gated;
         fail_output    <= pc.fo;
         hv_wake_armed  <= pc.hv_armed;
         gp_wake_armed  <= pc.gp_armed;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wake and level status; gated levels freeze while measuring
   assign hv_evt = pc.hv_armed & pc.hv_lvl & ~lvl_r[0];
   assign gp_evt = pc.gp_armed & pc.gp_lvl & ~lvl_r[1];

   // write-one clears, a same-cycle event wins over the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl_r     <= 2'h0;
         stat_lo_r <= 1'b0;
         stat_hi_r <= 1'b0;
      end else begin
         if (!meas_en_r) begin
            lvl_r <= {pc.gp_lvl, pc.hv_lvl};
         end
         stat_lo_r <= hv_evt | (stat_lo_r & ~(wr_stlo & wdata_r[0]));
         stat_hi_r <= gp_evt | (stat_hi_r & ~(wr_sthi & wdata_r[0]));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sleep refusal and the interrupt status
   assign sleep_fail = sleep_cmd & meas_en_r & ~other_wake_src;
   assign irq_set    = {gp_evt, hv_evt, en_refused | gpio_fail | sleep_fail};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         restart_req <= 1'b0;
         irq_stat_r  <= IRQ_RST;
         irq_en_r    <= IRQ_RST;
         irq         <= 1'b0;
      end else begin
         restart_req <= sleep_fail;
         // fail flag covers refused enable, pin config and sleep
         irq_stat_r  <= irq_set | (irq_stat_r & ~({3{wr_clr}}
                        & wdata_r[2:0]));
         if (wr_en) begin
            irq_en_r <= wdata_r[2:0];
         end
         irq <= |(irq_stat_r & irq_en_r);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read channel, answer one cycle after the address is taken
   always_comb begin
      rd_nxt = 32'h0000_0000;
      rd_map = 1'b1;
      unique case (s_axi_araddr)
         OFS_CTRL:     rd_nxt[1:0] = {fo_test_r, meas_en_r};
         OFS_GPIO:     rd_nxt[2:0] = gpio_cfg_r;
         OFS_WAKE_CFG: rd_nxt[4:0] = wake_cfg_r;
         OFS_STAT_LO:  rd_nxt[0]   = stat_lo_r;
         OFS_STAT_HI:  rd_nxt[0]   = stat_hi_r;
         OFS_LVL:      rd_nxt[1:0] = lvl_r;
         OFS_IRQ_STAT: rd_nxt[2:0] = irq_stat_r;
         OFS_IRQ_EN:   rd_nxt[2:0] = irq_en_r;
         OFS_IRQ_CLR:  rd_nxt      = 32'h0000_0000;
         OFS_STATUS:   rd_nxt[2:0] = {inputs_gated, restart_req,
                                      measure_switch};
         default:      rd_map      = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_nxt;
            s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   a_reset_idle: assert property (@(posedge aclk)
      !aresetn |=> !meas_en_r && !measure_switch && pull_en == 4'h0)
      else $error("path not idle after reset");

   a_switch_closes: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (meas_en_r && op_mode == MODE_NORMAL) |=> measure_switch)
      else $error("switch not closed in normal mode");

   a_switch_opens: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (op_mode != MODE_NORMAL || !meas_en_r) |=> !measure_switch)
      else $error("switch closed outside normal mode");

   a_enable_kept: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (meas_en_r && op_mode != MODE_NORMAL && !wr_ctrl) |=> meas_en_r)
      else $error("enable lost on mode change");

   a_pulls_off: assert property (@(posedge aclk)
      disable iff (!aresetn)
      meas_en_r |=> pull_en == 4'h0 && inputs_gated && !fail_output)
      else $error("pin still active while measuring");

   a_level_frozen: assert property (@(posedge aclk)
      disable iff (!aresetn)
      meas_en_r |=> $stable(lvl_r) && !hv_wake_armed && !gp_wake_armed)
      else $error("level status moved while measuring");

   a_sleep_restart: assert property (@(posedge aclk)
      disable iff (!aresetn)
      sleep_fail |=> restart_req && irq_stat_r[IRQ_FAIL_BIT])
      else $error("sleep not refused");

   a_gpio_fail: assert property (@(posedge aclk)
      disable iff (!aresetn)
      gpio_fail |=> irq_stat_r[IRQ_FAIL_BIT]
                    && gpio_cfg_r == $past(wdata_r[2:0]))
      else $error("pin config write not flagged");

   a_enable_refused: assert property (@(posedge aclk)
      disable iff (!aresetn)
      en_refused |=> !meas_en_r && irq_stat_r[IRQ_FAIL_BIT])
      else $error("enable not refused");

   a_failsafe_wake: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (op_mode == MODE_FAIL_SAFE && !meas_en_r) |=> hv_wake_armed)
      else $error("hv wake not armed in fail-safe");

endmodule // hv_measure_path_control

// ===== verilog/pin_ctl_if.sv
`timescale 1ns/1ps
// settings in, pin control decisions out
interface pin_ctl_if;
   import hv_meas_pkg::*;
   logic       meas_en;   // measurement path enabled
   mode_t      mode;      // current operating mode
   logic [2:0] gpio_cfg;  // pin function
   logic [3:0] pull_cfg;  // hv up, hv down, gp up, gp down
   logic       hv_hv_wake_enable;  // hv wake enable bit
   logic       fo_test;   // fail output test bit
   logic       hv_in;     // hv wake pin level
   logic       gp_in;     // shared pin level
   logic       sw;        // switch close request
   logic [3:0] pulls;     // effective pulls
   logic       fo;        // fail output drive
   logic       hv_armed;  // hv wake source live
   logic       gp_armed;  // shared pin wake live
   logic       hv_lvl;    // gated hv level
   logic       gp_lvl;    // gated shared pin level
   logic       gated;     // inputs gated

   modport core (output meas_en, mode, gpio_cfg, pull_cfg, hv_hv_wake_enable,
                 fo_test, hv_in, gp_in,
                 input sw, pulls, fo, hv_armed, gp_armed, hv_lvl,
                 gp_lvl, gated);
   modport gate (input meas_en, mode, gpio_cfg, pull_cfg, hv_hv_wake_enable,
                 fo_test, hv_in, gp_in,
                 output sw, pulls, fo, hv_armed, gp_armed, hv_lvl,
                 gp_lvl, gated);
endinterface

// ===== verilog/pin_gate.sv
`timescale 1ns/1ps
module pin_gate
   import hv_meas_pkg::*;
(
   pin_ctl_if.gate p  // settings in, decisions out
);

   logic normal;
   logic fsafe;

   assign normal = (p.mode == MODE_NORMAL);
   assign fsafe  = (p.mode == MODE_FAIL_SAFE);

   // switch closes only in normal mode; fail-safe keeps config, opens
   assign p.sw = p.meas_en & normal;

   // pulls and inputs dead while measuring; stored config is ignored
   assign p.pulls  = p.meas_en ? 4'h0 : p.pull_cfg;
   assign p.gated  = p.meas_en;
   assign p.hv_lvl = p.hv_in & ~p.meas_en;
   assign p.gp_lvl = p.gp_in & ~p.meas_en;

   // fail output and its test lose the pin to the measurement
   assign p.fo = ~p.meas_en & (p.gpio_cfg == GPIO_FO)
                 & (fsafe | p.fo_test);

   // wake enables stay stored but have no effect while measuring; fail-safe forces hv wake while the path is disabled
   assign p.hv_armed = ~p.meas_en & (p.hv_hv_wake_enable | fsafe);
   assign p.gp_armed = ~p.meas_en & (p.gpio_cfg == GPIO_WAKE);

endmodule // pin_gate
